// ---- logic/cbs_branch_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cbs_defs.vh"

module cbs_branch_unit #(
    parameter PC_W = 16
) (
    input wire clk_sys,
    input wire rst_n,
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [2:0] bit_sel,
    input wire [7:0] reg_value,
    input wire [7:0] io_value,
    input wire [7:0] core_status_register,
    input wire signed [6:0] offset_k,
    input wire next_is_long,
    input wire [PC_W-1:0] pc_in,
    output reg [PC_W-1:0] pc_next,
    output reg pc_load,
    output reg busy,
    output reg cond_taken
);

// ==========================================================
// operand bits
// all operands come from core logic on clk_sys, so no synchroniser is needed
wire [7:0] flags = core_status_register;
wire reg_bit = reg_value[bit_sel];
wire io_bit = io_value[bit_sel];
wire flag_sel = flags[bit_sel];
wire flag_c = flags[`CBS_FLAG_C];
wire flag_z = flags[`CBS_FLAG_Z];
wire flag_n = flags[`CBS_FLAG_N];
wire flag_v = flags[`CBS_FLAG_V];
// signed compare outcome; the flags are only ever read in this unit
wire sign_flag = flag_n ^ flag_v;

// ==========================================================
// opcode decode
// one strobe per operation keeps each condition next to its own rule
// skip operations
wire op_skip_reg_clr = (op_code == `CBS_OP_SKIP_REG_CLR);
wire op_skip_reg_set = (op_code == `CBS_OP_SKIP_REG_SET);
wire op_skip_io_clr = (op_code == `CBS_OP_SKIP_IO_CLR);
wire op_skip_io_set = (op_code == `CBS_OP_SKIP_IO_SET);

// selected-flag and zero-flag branches
wire op_br_flag_set = (op_code == `CBS_OP_BR_FLAG_SET);
wire op_br_flag_clr = (op_code == `CBS_OP_BR_FLAG_CLR);
wire op_br_eq = (op_code == `CBS_OP_BR_EQ);
wire op_br_ne = (op_code == `CBS_OP_BR_NE);

// carry-flag branches
wire op_br_cs = (op_code == `CBS_OP_BR_CS);
wire op_br_cc = (op_code == `CBS_OP_BR_CC);
wire op_br_sh = (op_code == `CBS_OP_BR_SH);
wire op_br_lo = (op_code == `CBS_OP_BR_LO);

// negative-flag and signed branches
wire op_br_mi = (op_code == `CBS_OP_BR_MI);
wire op_br_pl = (op_code == `CBS_OP_BR_PL);
wire op_br_ge = (op_code == `CBS_OP_BR_GE);
wire op_br_lt = (op_code == `CBS_OP_BR_LT);

// operation class; an unknown code belongs to neither and is ignored
wire is_skip = op_skip_reg_clr | op_skip_reg_set | op_skip_io_clr | op_skip_io_set;
wire is_branch_a = op_br_flag_set | op_br_flag_clr | op_br_eq | op_br_ne;
wire is_branch_b = op_br_cs | op_br_cc | op_br_sh | op_br_lo;
wire is_branch = is_branch_a | is_branch_b | op_br_mi | op_br_pl | op_br_ge | op_br_lt;
wire op_known = is_skip | is_branch;

// ==========================================================
// condition evaluation
// each term is gated by its own strobe, so at most one can be high
// skips
wire c_skip_reg_clr = op_skip_reg_clr & ~reg_bit;
wire c_skip_reg_set = op_skip_reg_set & reg_bit;
wire c_skip_io_clr = op_skip_io_clr & ~io_bit;
wire c_skip_io_set = op_skip_io_set & io_bit;

// selected flag and zero flag
wire c_br_flag_set = op_br_flag_set & flag_sel;
wire c_br_flag_clr = op_br_flag_clr & ~flag_sel;
wire c_br_eq = op_br_eq & flag_z;
wire c_br_ne = op_br_ne & ~flag_z;

// carry flag
wire c_br_cs = op_br_cs & flag_c;
wire c_br_cc = op_br_cc & ~flag_c;
wire c_br_sh = op_br_sh & ~flag_c;
wire c_br_lo = op_br_lo & flag_c;

// negative flag and signed compare
wire c_br_mi = op_br_mi & flag_n;
wire c_br_pl = op_br_pl & ~flag_n;
wire c_br_ge = op_br_ge & ~sign_flag;
wire c_br_lt = op_br_lt & sign_flag;

// the op's condition is the or of all terms
wire cond_skip = c_skip_reg_clr | c_skip_reg_set | c_skip_io_clr | c_skip_io_set;
wire cond_zero = c_br_flag_set | c_br_flag_clr | c_br_eq | c_br_ne;
wire cond_carry = c_br_cs | c_br_cc | c_br_sh | c_br_lo;
wire cond_sign = c_br_mi | c_br_pl | c_br_ge | c_br_lt;
wire cond = cond_skip | cond_zero | cond_carry | cond_sign;

// ==========================================================
// target computation
// the offset is sign extended to the pc width, so targets wrap at the top
wire [PC_W-1:0] k_ext = {{(PC_W-7){offset_k[6]}}, offset_k};
wire [PC_W-1:0] step_one = `CBS_STEP_ONE;
wire [PC_W-1:0] step_two = `CBS_STEP_TWO;
wire [PC_W-1:0] step_three = `CBS_STEP_THREE;
wire [PC_W-1:0] step_skip = next_is_long ? step_three : step_two;
// the three candidate targets, all relative to the op's own address
wire [PC_W-1:0] pc_seq = pc_in + step_one;
wire [PC_W-1:0] pc_skip = pc_in + step_skip;
wire [PC_W-1:0] pc_rel = pc_in + k_ext + step_one;

// pick the new pc and the length of the op
// an untaken op always lands on the next word, whatever its class
reg [PC_W-1:0] target;
reg [1:0] cycles;
always @* begin
    target = pc_seq;
    cycles = `CBS_CYC_ONE;
    if (cond && is_skip) begin
        target = pc_skip;
        cycles = next_is_long ? `CBS_CYC_THREE : `CBS_CYC_TWO;
    end else if (cond && is_branch) begin
        target = pc_rel;
        cycles = `CBS_CYC_TWO;
    end
end

// ==========================================================
// cycle sequencing
// idle: ready for a new op
// hold: first extra cycle of a long skip
// last: the cycle before pc_load shows
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_HOLD = 3'h2;
localparam [2:0] ST_LAST = 3'h4;
reg [2:0] state_q;
reg [2:0] state_d;

// ops are taken only in idle; an offer while busy is dropped, not queued
wire accept = op_valid && op_known && (state_q == ST_IDLE);

// length of an accepted op, one strobe each
wire acc_one = accept && (cycles == `CBS_CYC_ONE);
wire acc_two = accept && (cycles == `CBS_CYC_TWO);
wire acc_three = accept && (cycles == `CBS_CYC_THREE);

// next state
always @* begin
    state_d = state_q;
    case (state_q)
        ST_IDLE: begin
            if (acc_three) begin
                state_d = ST_HOLD;
            end else if (acc_two) begin
                state_d = ST_LAST;
            end
        end
        ST_HOLD: begin
            state_d = ST_LAST;
        end
        ST_LAST: begin
            state_d = ST_IDLE;
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
end

// outputs of the next cycle
// pc_load marks the last cycle of every op, busy all the cycles before it
wire load_d = acc_one || (state_q == ST_LAST);
wire busy_d = (state_d == ST_HOLD) || (state_d == ST_LAST);

// state and handshake; this unit has no flag outputs, so flags stay untouched
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= ST_IDLE;
        pc_load <= 1'b0;
        busy <= 1'b0;
    end else begin
        state_q <= state_d;
        pc_load <= load_d;
        busy <= busy_d;
    end
end

// captured result; held until the next accepted op so the core may read it late
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        pc_next <= `CBS_PC_RESET;
        cond_taken <= 1'b0;
    end else if (accept) begin
        pc_next <= target;
        cond_taken <= cond;
    end
end

endmodule
`default_nettype wire

// ---- pkg/cbs_defs.vh ----
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH
// ==========================================================
// operation codes on op_code
`define CBS_OP_NONE 5'h00
`define CBS_OP_SKIP_REG_CLR 5'h01
`define CBS_OP_SKIP_REG_SET 5'h02
`define CBS_OP_SKIP_IO_CLR 5'h03
`define CBS_OP_SKIP_IO_SET 5'h04
`define CBS_OP_BR_FLAG_SET 5'h05
`define CBS_OP_BR_FLAG_CLR 5'h06
`define CBS_OP_BR_EQ 5'h07
`define CBS_OP_BR_NE 5'h08
`define CBS_OP_BR_CS 5'h09
`define CBS_OP_BR_CC 5'h0a
`define CBS_OP_BR_SH 5'h0b
`define CBS_OP_BR_LO 5'h0c
`define CBS_OP_BR_MI 5'h0d
`define CBS_OP_BR_PL 5'h0e
`define CBS_OP_BR_GE 5'h0f
`define CBS_OP_BR_LT 5'h10
// ==========================================================
// op lengths in cycles
`define CBS_CYC_ONE 2'h1
`define CBS_CYC_TWO 2'h2
`define CBS_CYC_THREE 2'h3
// ==========================================================
// status register flag positions
`define CBS_FLAG_C 3'h0
`define CBS_FLAG_Z 3'h1
`define CBS_FLAG_N 3'h2
`define CBS_FLAG_V 3'h3
// ==========================================================
// word steps and reset value
`define CBS_STEP_ONE 16'h0001
`define CBS_STEP_TWO 16'h0002
`define CBS_STEP_THREE 16'h0003
`define CBS_PC_RESET 16'h0000
`endif

// ---- bench/cbs_branch_unit_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbs_chk #(parameter PC_W = 16) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic next_is_long,
    input wire logic pc_load,
    input wire logic busy,
    input wire logic cond_taken,
    input wire logic [4:0] op_code,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] io_value,
    input wire logic [7:0] core_status_register,
    input wire logic signed [6:0] offset_k,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [PC_W-1:0] pc_next
);
    // ==========
    // accepted op and sign-extended branch target
    wire logic acc = op_valid && !busy && op_code != 5'h00 && op_code <= 5'h10;
    wire logic [PC_W-1:0] tgt = pc_in + {{(PC_W-7){offset_k[6]}}, offset_k} + 1'b1;
    wire logic [7:0] sr = core_status_register;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_br; acc && op_code > 5'h04 ##1 cond_taken; endsequence
    sequence s_long; acc && op_code < 5'h05 && next_is_long ##1 cond_taken; endsequence
    sequence s_short; acc && op_code < 5'h05 && !next_is_long ##1 cond_taken; endsequence
    a_branch_wait: assert property (s_br |-> busy && !pc_load ##1 pc_load && !busy)
        else $error("taken branch timing wrong");
    a_branch_pc: assert property (s_br |-> pc_next == $past(tgt))
        else $error("branch target wrong");
    a_untaken_step: assert property (acc ##1 !cond_taken |-> pc_load && !busy &&
        pc_next == $past(pc_in) + 1'b1) else $error("untaken step wrong");
    a_short_skip: assert property (s_short |-> busy && pc_next == $past(pc_in) + 2'h2
        ##1 pc_load) else $error("short skip wrong");
    a_long_skip: assert property (s_long |-> busy[*2] ##1 pc_load &&
        pc_next == $past(pc_in, 3) + 2'h3) else $error("long skip wrong");
    a_eq_cond: assert property (acc && op_code == 5'h07 |=>
        cond_taken == $past(sr[1])) else $error("equal decision wrong");
    a_carry_cond: assert property (acc && op_code == 5'h09 |=>
        cond_taken == $past(sr[0])) else $error("carry decision wrong");
    a_ge_cond: assert property (acc && op_code == 5'h0f |=>
        cond_taken == $past(sr[2] ~^ sr[3])) else $error("signed ge decision wrong");
    a_io_clear: assert property (acc && op_code == 5'h03 |=>
        cond_taken == !$past(io_value[bit_sel])) else $error("io clear decision wrong");
    a_minus_cond: assert property (acc && op_code == 5'h0d |=>
        cond_taken == $past(sr[2])) else $error("minus decision wrong");
endmodule
bind cbs_branch_unit cbs_chk #(.PC_W(PC_W)) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .op_valid(op_valid),
    .next_is_long(next_is_long),
    .pc_load(pc_load),
    .busy(busy),
    .cond_taken(cond_taken),
    .op_code(op_code),
    .bit_sel(bit_sel),
    .reg_value(reg_value),
    .io_value(io_value),
    .core_status_register(core_status_register),
    .offset_k(offset_k),
    .pc_in(pc_in),
    .pc_next(pc_next)
);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cbs_defs.vh"
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, op_valid = 1'b0, next_is_long = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] reg_value = 8'h00, io_value = 8'h00, core_status_register = 8'h00;
    logic signed [6:0] offset_k = 7'h00;
    logic [15:0] pc_in = 16'h0000, pc_next;
    logic pc_load, busy, cond_taken;
    int fails = 0, checks = 0, n;
    // ==========
    always #4 clk_sys = ~clk_sys;
    cbs_branch_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .bit_sel(bit_sel), .reg_value(reg_value), .io_value(io_value),
        .core_status_register(core_status_register), .offset_k(offset_k),
        .next_is_long(next_is_long), .pc_in(pc_in), .pc_next(pc_next), .pc_load(pc_load),
        .busy(busy), .cond_taken(cond_taken));
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one op driven on the falling edge, held one cycle, then wait for pc_load
    task automatic op(input logic [4:0] c, input logic [7:0] sr, input logic [2:0] b,
        input logic [7:0] v, input logic lng, input logic [6:0] k, input logic [15:0] pc,
        input logic [31:0] cyc, pe, input logic tk);
        @(negedge clk_sys);
        op_code = c;
        core_status_register = sr;
        bit_sel = b;
        reg_value = v;
        io_value = v;
        next_is_long = lng;
        offset_k = k;
        pc_in = pc;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        for (n = 1; !pc_load && n < 8; n++) @(negedge clk_sys);
        check("cycles", n, cyc);
        check("busy", busy, 32'h0);
        check("taken", cond_taken, tk);
        check("pc_next", pc_next, pe);
    endtask
    task t_eq;
        op(`CBS_OP_BR_EQ, 8'h02, 3'h0, 8'h00, 1'b0, 7'h7d,
            16'h0010, 2, 16'h000e, 1'b1);
        op(`CBS_OP_BR_NE, 8'h02, 3'h0, 8'h00, 1'b0, 7'h05,
            16'h0220, 1, 16'h0221, 1'b0);
    endtask
    task t_ge;
        op(`CBS_OP_BR_GE, 8'h04, 3'h0, 8'h00, 1'b0, 7'h05,
            16'h0020, 1, 16'h0021, 1'b0);
        op(`CBS_OP_BR_LT, 8'h08, 3'h0, 8'h00, 1'b0, 7'h7f,
            16'h0270, 2, 16'h0270, 1'b1);
    endtask
    task t_io;
        op(`CBS_OP_SKIP_IO_CLR, 8'h00, 3'h5, 8'hdf, 1'b0, 7'h00,
            16'h0030, 2, 16'h0032, 1'b1);
    endtask
    // wraps at the top of program space on purpose
    task t_reg;
        op(`CBS_OP_SKIP_REG_SET, 8'h00, 3'h7, 8'h80, 1'b1, 7'h00,
            16'hfffe, 3, 16'h0001, 1'b1);
        op(`CBS_OP_SKIP_REG_CLR, 8'h00, 3'h2, 8'hfb, 1'b0, 7'h00,
            16'h0200, 2, 16'h0202, 1'b1);
    endtask
    task t_carry;
        op(`CBS_OP_BR_CS, 8'h01, 3'h0, 8'h00, 1'b0, 7'h00,
            16'h0040, 2, 16'h0041, 1'b1);
        op(`CBS_OP_BR_CC, 8'h01, 3'h0, 8'h00, 1'b0, 7'h00,
            16'h0050, 1, 16'h0051, 1'b0);
        op(`CBS_OP_BR_SH, 8'h00, 3'h0, 8'h00, 1'b0, 7'h40,
            16'h0230, 2, 16'h01f1, 1'b1);
        op(`CBS_OP_BR_LO, 8'h00, 3'h0, 8'h00, 1'b0, 7'h10,
            16'h0240, 1, 16'h0241, 1'b0);
    endtask
    task t_flag;
        op(`CBS_OP_BR_FLAG_CLR, 8'h00, 3'h3, 8'h00, 1'b0, 7'h3f,
            16'h0100, 2, 16'h0140, 1'b1);
        op(`CBS_OP_BR_FLAG_SET, 8'h08, 3'h3, 8'h00, 1'b0, 7'h01,
            16'h0210, 2, 16'h0212, 1'b1);
    endtask
    task t_neg;
        op(`CBS_OP_BR_MI, 8'h04, 3'h0, 8'h00, 1'b0, 7'h02,
            16'h0250, 2, 16'h0253, 1'b1);
        op(`CBS_OP_BR_PL, 8'h04, 3'h0, 8'h00, 1'b0, 7'h02,
            16'h0260, 1, 16'h0261, 1'b0);
    endtask
    task conclude;
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        t_eq;
        t_ge;
        t_io;
        t_reg;
        t_carry;
        t_flag;
        t_neg;
        conclude;
    end
    // watchdog: the whole run needs well under a hundred cycles
    initial begin
        #4000;
        fails++;
        conclude;
    end
endmodule
`default_nettype wire
